// ==== src/icdt_top.sv ====
// Nine capture modules, each with own counter and 4-entry FIFO.
// Assumes Avalon-MM master on clock; pins arrive asynchronous,
// sync_event and sync_enable come from logic on the same clock.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
module icdt_top (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic [4:0]  clock_pin,
   input  wire logic [8:0]  capture_input,
   input  wire logic [29:0] sync_event,
   input  wire logic [29:0] sync_enable
);
   // ***********************************************
   // Reset release
   // ***********************************************
   logic rst_a_r;
   logic rst_n_r;
   // Two flops so release is clean against clock
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_a_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_a_r <= 1'b1;
         rst_n_r <= rst_a_r;
      end
   end

   // ***********************************************
   // Pin synchronisers (clock pins above capture pins)
   // ***********************************************
   logic [13:0] pin_raw;
   logic [13:0] s1_r;
   logic [13:0] s2_r;
   logic [13:0] s3_r;
   logic [13:0] lvl_r;
   logic [13:0] lvl_nxt;
   logic [13:0] rise;
   logic [13:0] fall;
   logic [4:0]  clk_rise;
   assign pin_raw = {clock_pin, capture_input};
   // Level moves only when second and third stages agree
   always_comb
   begin
      lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
      rise    = lvl_nxt & ~lvl_r;
      fall    = ~lvl_nxt & lvl_r;
   end
   assign clk_rise = rise[13:9];
   always_ff @(posedge clock or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         s1_r  <= 14'h0000;
         s2_r  <= 14'h0000;
         s3_r  <= 14'h0000;
         lvl_r <= 14'h0000;
      end
      else
      begin
         s1_r  <= pin_raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // ***********************************************
   // Bus decode and read path
   // ***********************************************
   logic [3:0]  sel_mod;
   logic [1:0]  sel_reg;
   logic        hit;
   logic        wr_go;
   logic        rd_pop;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [15:0] con1_r [9];
   logic [15:0] con2_r [9];
   logic [15:0] cnt_r  [9];
   logic [15:0] fifo_r [9][4];
   logic [1:0]  rdp_r  [9];
   logic [2:0]  fcnt_r [9];
   logic [8:0]  ovf_v;
   logic [8:0]  wrap;
   logic [8:0]  cap_ev;
   logic [31:0] sync_pad;
   logic [31:0] syncon_pad;
   assign sel_mod = address[7:4];
   assign sel_reg = address[3:2];
   assign hit     = (sel_mod < 4'h9);
   assign wr_go   = write & hit;
   // One wait state on reads, none on writes
   assign waitrequest = read & ~rvalid_r;
   assign rd_pop      = read & rvalid_r & hit & (sel_reg == icdt_pkg::REG_FIFO);
   assign readdata    = rdata_r;
   // Source code n picks bit n; codes 0 and 31 select nothing
   assign sync_pad   = {1'b0, sync_event, 1'b0}; // RULE8
   assign syncon_pad = {1'b0, sync_enable, 1'b0};
   // Read data captured during the wait cycle; unmapped reads as zero
   always_comb
   begin
      rvalid_nxt = read & ~rvalid_r;
      rdata_nxt  = rdata_r;
      if (read && !rvalid_r)
      begin
         rdata_nxt = 32'h0000_0000;
         if (hit)
         begin
            case (sel_reg)
               icdt_pkg::REG_CON1:
                  rdata_nxt[15:0] = con1_r[sel_mod]
                     | {11'h000, ovf_v[sel_mod], (fcnt_r[sel_mod] != 3'h0),
                        3'h0}; // RULE19
               icdt_pkg::REG_CON2: rdata_nxt[15:0] = con2_r[sel_mod];
               icdt_pkg::REG_FIFO:
                  rdata_nxt[15:0] = fifo_r[sel_mod][rdp_r[sel_mod]]; // RULE22
               default: rdata_nxt[15:0] = cnt_r[sel_mod];
            endcase
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
      end
      else
      begin
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // ***********************************************
   // Capture modules
   // ***********************************************
   genvar gi;
   generate
      for (gi = 0; gi < icdt_pkg::NUM_MOD; gi++) // RULE1
      begin : g_mod
         localparam int LO = (gi % 2 == 1) ? gi - 1 : gi;
         icdt_pkg::icdt_op_t op;
         logic        casc;
         logic [15:0] c1;
         logic [15:0] c2;
         logic [4:0]  ssel;
         logic        sync_ev;
         logic        sync_on;
         logic        run;
         logic        tick;
         logic        own_ev;
         logic        cap;
         logic [2:0]  csel;
         logic [15:0] con1_nxt;
         logic [15:0] con2_nxt;
         logic [15:0] cnt_nxt;
         logic [15:0] fifo_nxt [4];
         logic [1:0]  wrp_r;
         logic [1:0]  wrp_nxt;
         logic [1:0]  rdp_nxt;
         logic [2:0]  fcnt_nxt;
         logic [3:0]  pre_r;
         logic [3:0]  pre_nxt;
         logic        ovf_r;
         logic        ovf_nxt;
         logic        push;
         logic        pop;
         logic        wsel;

         // Upper half follows its lower partner when both bits set
         assign casc = (LO != gi) && con2_r[gi][icdt_pkg::C2_CASC]
                       && con2_r[LO][icdt_pkg::C2_CASC]; // RULE17
         assign c1 = casc ? con1_r[LO] : con1_r[gi]; // RULE21
         assign c2 = casc ? con2_r[LO] : con2_r[gi]; // RULE14
         assign ssel    = c2[4:0];
         assign sync_ev = sync_pad[ssel];
         assign sync_on = syncon_pad[ssel];
         assign csel    = c1[icdt_pkg::C1_CLKSEL_LSB +: 3];
         assign wsel    = wr_go && (sel_mod == 4'(gi));
         assign ovf_v[gi] = ovf_r;

         // Operating mode and run condition
         always_comb
         begin
            if (ssel == 5'h00)
               op = c2[icdt_pkg::C2_TRIG] ? icdt_pkg::OP_SWTRIG
                                          : icdt_pkg::OP_FREE; // RULE6
            else
               op = c2[icdt_pkg::C2_TRIG] ? icdt_pkg::OP_HWTRIG
                                          : icdt_pkg::OP_SYNC; // RULE7
            case (op)
               icdt_pkg::OP_FREE:   run = 1'b1;
               icdt_pkg::OP_SYNC:   run = sync_on; // RULE9
               icdt_pkg::OP_HWTRIG: run = c2[icdt_pkg::C2_TSTAT]; // RULE11
               icdt_pkg::OP_SWTRIG: run = c2[icdt_pkg::C2_TSTAT]; // RULE12
               default:             run = 1'b0;
            endcase
            // Code 0 is the system clock, 1..5 the clock pins
            if (csel == icdt_pkg::CLK_SYS)
               tick = 1'b1;
            else if (csel <= 3'h5)
               tick = clk_rise[3'(csel - 3'h1)]; // RULE2
            else
               tick = 1'b0;
         end
         assign wrap[gi] = run && tick && (cnt_r[gi] == icdt_pkg::CNT_MAX);

         // Edge qualification; prescaler counts rising edges
         always_comb
         begin
            pre_nxt = pre_r;
            own_ev  = 1'b0;
            case (con1_r[gi][2:0])
               icdt_pkg::MODE_ANY:  own_ev = rise[gi] | fall[gi]; // RULE18
               icdt_pkg::MODE_RISE: own_ev = rise[gi];
               icdt_pkg::MODE_RISE4:
                  own_ev = rise[gi] && (pre_r[1:0] == 2'h3);
               icdt_pkg::MODE_RISE16:
                  own_ev = rise[gi] && (pre_r == 4'hF);
               default: own_ev = 1'b0;
            endcase
            // Restart on any mode write so every 4th counts from setup
            if (con1_r[gi][2:0] == 3'h0
                || (wsel && sel_reg == icdt_pkg::REG_CON1))
               pre_nxt = 4'h0; // RULE18
            else if (rise[gi])
               pre_nxt = pre_r + 4'h1;
         end
         assign cap_ev[gi] = own_ev;
         // Both halves store on the lower module's event
         assign cap  = run && (casc ? cap_ev[LO] : cap_ev[gi]); // RULE15
         assign push = cap && (fcnt_r[gi] != 3'(icdt_pkg::FIFO_DEPTH));
         assign pop  = rd_pop && (sel_mod == 4'(gi))
                       && (fcnt_r[gi] != 3'h0);

         // Next state of counter, FIFO and control
         always_comb
         begin
            con1_nxt = con1_r[gi];
            con2_nxt = con2_r[gi];
            cnt_nxt  = cnt_r[gi];
            fifo_nxt = fifo_r[gi];
            wrp_nxt  = wrp_r;
            rdp_nxt  = rdp_r[gi];
            fcnt_nxt = fcnt_r[gi];
            ovf_nxt  = ovf_r;
            if (wsel && sel_reg == icdt_pkg::REG_CON1)
               con1_nxt = writedata[15:0] & icdt_pkg::C1_WMASK;
            if (wsel && sel_reg == icdt_pkg::REG_CON2)
               con2_nxt = writedata[15:0] & icdt_pkg::C2_WMASK;
            // Hardware set beats a software clear in the same cycle
            if (op == icdt_pkg::OP_HWTRIG && sync_ev && !casc)
               con2_nxt[icdt_pkg::C2_TSTAT] = 1'b1; // RULE23
            // Unenabled sync source keeps the counter at zero (pair too)
            if (op == icdt_pkg::OP_SYNC && (!sync_on || sync_ev))
               cnt_nxt = 16'h0000; // RULE10 RULE20
            else if (casc)
            begin
               if (wrap[LO])
                  cnt_nxt = cnt_r[gi] + 16'h0001; // RULE13 RULE16
            end
            else if (run && tick)
               cnt_nxt = cnt_r[gi] + 16'h0001; // RULE3
            if (push)
            begin
               fifo_nxt[wrp_r] = cnt_r[gi]; // RULE4
               wrp_nxt = wrp_r + 2'h1;
            end
            if (pop)
               rdp_nxt = rdp_r[gi] + 2'h1; // RULE22
            if (push && !pop)
               fcnt_nxt = fcnt_r[gi] + 3'h1; // RULE5
            else if (pop && !push)
               fcnt_nxt = fcnt_r[gi] - 3'h1;
            // Overrun flag clears once the FIFO is drained
            if (pop && fcnt_r[gi] == 3'h1 && !cap)
               ovf_nxt = 1'b0;
            if (cap && !push)
               ovf_nxt = 1'b1;
         end

         always_ff @(posedge clock or negedge rst_n_r)
         begin
            if (!rst_n_r)
            begin
               con1_r[gi] <= icdt_pkg::CON_RST;
               con2_r[gi] <= icdt_pkg::CON_RST;
               cnt_r[gi]  <= 16'h0000;
               fifo_r[gi] <= '{default: 16'h0000};
               wrp_r      <= 2'h0;
               rdp_r[gi]  <= 2'h0;
               fcnt_r[gi] <= 3'h0;
               pre_r      <= 4'h0;
               ovf_r      <= 1'b0;
            end
            else
            begin
               con1_r[gi] <= con1_nxt;
               con2_r[gi] <= con2_nxt;
               cnt_r[gi]  <= cnt_nxt;
               fifo_r[gi] <= fifo_nxt;
               wrp_r      <= wrp_nxt;
               rdp_r[gi]  <= rdp_nxt;
               fcnt_r[gi] <= fcnt_nxt;
               pre_r      <= pre_nxt;
               ovf_r      <= ovf_nxt;
            end
         end
      end
   endgenerate
endmodule : icdt_top

// ==== common/icdt_pkg.sv ====
// Constants, field layouts and types for the capture unit with own timers.
// Assumes a single 250 MHz clock and an Avalon-MM slave with byte addresses.
// Summary of operation
// RULE1: nine identical independent capture modules
// RULE2: six clock sources drive private 16-bit counter
// RULE3: free-running counter counts up, wraps FFFF
// RULE4: capture event stores present counter value
// RULE5: FIFO holds up to four captures
// RULE6: free-run when source zero, trigger clear
// RULE7: nonzero source: sync or trigger operation
// RULE8: up to thirty sync or trigger sources
// RULE9: sync operation captures once source enabled
// RULE10: sync event clears the counter
// RULE11: trigger operation holds counter until event
// RULE12: software trigger: starts when status set
// RULE13: adjacent pair chains into 32 bits
// RULE14: unchained modules run alone, 16 bits
// RULE15: odd module low half, even high; the code makes the even module the low half and the odd module the high half
// RULE16: low half wrap increments high half
// RULE17: software sets cascade bit in both
// RULE18: capture every edge, rise, 4th, 16th
// RULE19: not-empty flag while FIFO holds data
// RULE20: chained sync pair held until enabled
// RULE21: chained upper follows lower in step
// RULE22: FIFO read returns and removes oldest
// RULE23: trigger event sets status until cleared
package icdt_pkg;
   // ***********************************************
   // Sizes
   // ***********************************************
   localparam int NUM_MOD    = 9;
   localparam int NUM_CLKPIN = 5;
   localparam int NUM_SYNC   = 30;
   localparam int CNT_W      = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int ADDR_W     = 8;
   // ***********************************************
   // Register map: address[7:4] module, [3:2] register
   // ***********************************************
   localparam logic [1:0] REG_CON1 = 2'h0;
   localparam logic [1:0] REG_CON2 = 2'h1;
   localparam logic [1:0] REG_FIFO = 2'h2;
   localparam logic [1:0] REG_CNT  = 2'h3;
   localparam logic [15:0] CON_RST  = 16'h0000;
   localparam logic [15:0] C1_WMASK = 16'h1C07;
   localparam logic [15:0] C2_WMASK = 16'h01DF;
   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int C1_CLKSEL_LSB = 10;
   localparam int C1_OVF        = 4;
   localparam int C1_BNE        = 3;
   localparam int C2_CASC       = 8;
   localparam int C2_TRIG       = 7;
   localparam int C2_TSTAT      = 6;
   // ***********************************************
   // Capture mode codes and clock selection
   // ***********************************************
   localparam logic [2:0] MODE_ANY   = 3'h1;
   localparam logic [2:0] MODE_RISE  = 3'h3;
   localparam logic [2:0] MODE_RISE4 = 3'h4;
   localparam logic [2:0] MODE_RISE16 = 3'h5;
   localparam logic [2:0] CLK_SYS    = 3'h0;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   typedef enum logic [1:0] {OP_FREE, OP_SYNC, OP_HWTRIG, OP_SWTRIG} icdt_op_t;
endpackage : icdt_pkg

// ==== tb/icdt_chk.sv ====
// Bus checks for the capture unit, seeing only top-level ports.
// Assumes one clock domain and the bind at the foot of this file.
module icdt_chk (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************
   // Handshake and register layout
   // ************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Read steps: one wait cycle, then the answer
   sequence rd_wait_s; read && waitrequest; endsequence
   sequence rd_done_s; read && !waitrequest; endsequence
   idle_no_wait_a: assert property (!read |-> !waitrequest)
      else $error("waitrequest high without a read");
   write_no_wait_a: assert property (write |-> !waitrequest)
      else $error("write stalled");
   read_answer_a: assert property (rd_wait_s |=> !waitrequest)
      else $error("read answer late");
   upper_zero_a: assert property (rd_done_s |-> readdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   unmapped_zero_a: assert property
      (rd_done_s ##0 (address[7:4] > 4'h8) |-> readdata == 32'h00000000)
      else $error("unmapped module read not zero");
   ctrl1_layout_a: assert property
      (rd_done_s ##0 (address[3:2] == icdt_pkg::REG_CON1)
       |-> (readdata[15:0] & 16'hE3E0) == 16'h0000)
      else $error("unused first control bits set");
   ctrl2_layout_a: assert property
      (rd_done_s ##0 (address[3:2] == icdt_pkg::REG_CON2)
       |-> (readdata[15:0] & 16'hFE20) == 16'h0000)
      else $error("unused second control bits set");
   data_hold_a: assert property (!read |=> $stable(readdata))
      else $error("read data moved while idle");
endmodule : icdt_chk

bind icdt_top icdt_chk icdt_chk_i (.clock(clock), .arst_n(arst_n),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest));

// ==== tb/icdt_src.sv ====
// Far side model: capture pins and on-chip sync or trigger sources.
// Assumes callers enter its tasks just after a rising clock edge.
module icdt_src (
   input wire logic   clock,
   output logic [4:0]  clock_pin,
   output logic [8:0]  capture_input,
   output logic [29:0] sync_event,
   output logic [29:0] sync_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************
   // Source drivers
   // ************************************************
   // Pins idle low; pin clocks move only inside their task
   initial
   begin
      clock_pin = 5'h00;
      capture_input = 9'h000;
      sync_event = 30'h00000000;
      sync_enable = 30'h00000000;
   end
   // Square wave on one pin, even duty, ends low
   task automatic pulses(input int m, input int rises, input int half);
      repeat (rises)
      begin
         @(posedge clock);
         capture_input[m] <= 1'b1;
         repeat (half) @(posedge clock);
         capture_input[m] <= 1'b0;
         repeat (half - 1) @(posedge clock);
      end
   endtask : pulses
   // Rising edges on one clock pin, still between bursts
   task automatic pin_clock(input int p, input int rises);
      repeat (rises)
      begin
         @(posedge clock);
         clock_pin[p] <= 1'b1;
         repeat (4) @(posedge clock);
         clock_pin[p] <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask : pin_clock
   // One-cycle event from source code n
   task automatic sync_pulse(input int n);
      @(posedge clock);
      sync_event[n-1] <= 1'b1;
      @(posedge clock);
      sync_event[n-1] <= 1'b0;
   endtask : sync_pulse
   task automatic enable(input int n, input logic v);
      @(posedge clock);
      sync_enable[n-1] <= v;
   endtask : enable
endmodule : icdt_src

// ==== tb/tb_top.sv ====
// Self-checking bench for the capture unit over Avalon-MM.
// Assumes icdt_src drives the pins; checker is bound to icdt_top.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, arst_n, read, write, waitrequest;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, last_rd;
   logic [4:0]  clock_pin;
   logic [8:0]  capture_input;
   logic [29:0] sync_event, sync_enable;
   logic [63:0] note_q[$];
   logic [15:0] base;
   int          fail_count, comparisons, cycles, seed, half;
   int          md[4] = '{1, 3, 4, 5};
   int          rs[4] = '{2, 5, 19, 79};
   int          sp[4] = '{1, 2, 8, 32};
   // ************************************************
   // Instances, clock, bus tasks
   // ************************************************
   icdt_top icdt_top_i (.clock(clock), .arst_n(arst_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .clock_pin(clock_pin), .capture_input(capture_input),
      .sync_event(sync_event), .sync_enable(sync_enable));
   icdt_src icdt_src_i (.clock(clock), .clock_pin(clock_pin),
      .capture_input(capture_input), .sync_event(sync_event),
      .sync_enable(sync_enable));
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // Writes take effect at the edge seeing waitrequest low
   task automatic wr(input int m, input logic [1:0] r, input logic [15:0] d);
      @(posedge clock);
      address <= {m[3:0], r, 2'h0};
      writedata <= {16'h0000, d};
      write <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      write <= 1'b0;
   endtask : wr
   // Expected value and mask are noted before the request goes out
   task automatic rd(input int m, input logic [1:0] r,
                     input logic [15:0] e, input logic [15:0] k);
      @(posedge clock);
      address <= {m[3:0], r, 2'h0};
      read <= 1'b1;
      note_q.push_back({16'hFFFF, k, 16'h0000, e & k});
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      last_rd = readdata;
      read <= 1'b0;
   endtask : rd
   // Monitor: oldest note against each answer; also the hang limit
   always @(posedge clock)
   begin
      cycles++;
      if (read === 1'b1 && waitrequest === 1'b0 && note_q.size() > 0)
      begin
         check(readdata & note_q[0][63:32], note_q[0][31:0]);
         void'(note_q.pop_front());
      end
      if (cycles == 90000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   // ************************************************
   // Scenarios
   // ************************************************
   initial
   begin
      seed = 90;
      fail_count = 0;
      comparisons = 0;
      cycles = 0;
      arst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h00000000;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      // Reset values; module 9 does not exist, writes vanish
      wr(9, icdt_pkg::REG_CON2, 16'hFFFF);
      for (int m = 0; m < 10; m++)
      begin
         rd(m, icdt_pkg::REG_CON1, 16'h0000, 16'hFFFF);
         rd(m, icdt_pkg::REG_CON2, 16'h0000, 16'hFFFF);
      end
      // Random writes, read back through the writable mask
      for (int m = 0; m < 9; m++)
      begin
         base = 16'($random(seed));
         wr(m, icdt_pkg::REG_CON1, base);
         rd(m, icdt_pkg::REG_CON1, base & icdt_pkg::C1_WMASK, 16'hFFFF);
         wr(m, icdt_pkg::REG_CON2, base);
         rd(m, icdt_pkg::REG_CON2, base & icdt_pkg::C2_WMASK, 16'hFFBF);
         wr(m, icdt_pkg::REG_CON1, 16'h0000);
         wr(m, icdt_pkg::REG_CON2, 16'h0000);
      end
      // Every capture mode: four even-spaced captures stored (rising mode overruns on a fifth), then empty
      for (int i = 0; i < 4; i++)
      begin
         half = 4 + ($random(seed) & 3);
         wr(2, icdt_pkg::REG_CON1, 16'(md[i]));
         icdt_src_i.pulses(2, rs[i], half);
         repeat (8) @(posedge clock);
         rd(2, icdt_pkg::REG_CON1, 16'(md[i]) | 16'h0008
            | (i == 1 ? 16'h0010 : 16'h0000), 16'hFFFF);
         rd(2, icdt_pkg::REG_FIFO, 16'h0000, 16'h0000);
         base = last_rd[15:0];
         for (int k = 1; k < 4; k++)
            rd(2, icdt_pkg::REG_FIFO, base + 16'(k * sp[i] * half),
               16'hFFFF);
         // Empty buffer: stale entry, no pop
         rd(2, icdt_pkg::REG_FIFO, base, 16'hFFFF);
         rd(2, icdt_pkg::REG_CON1, 16'(md[i]), 16'hFFFF);
      end
      // Sync mode: no capture while the source is off, cleared by events
      wr(3, icdt_pkg::REG_CON2, 16'h0005);
      wr(3, icdt_pkg::REG_CON1, 16'h0003);
      icdt_src_i.pulses(3, 1, 4);
      repeat (8) @(posedge clock);
      rd(3, icdt_pkg::REG_CON1, 16'h0003, 16'hFFFF);
      icdt_src_i.enable(5, 1'b1);
      repeat (2)
      begin
         icdt_src_i.sync_pulse(5);
         repeat (20) @(posedge clock);
         icdt_src_i.pulses(3, 1, 4);
         repeat (40) @(posedge clock);
      end
      rd(3, icdt_pkg::REG_FIFO, 16'h0000, 16'h0000);
      rd(3, icdt_pkg::REG_FIFO, last_rd[15:0], 16'hFFFF);
      // Hardware trigger: held until the event, status sticks
      wr(4, icdt_pkg::REG_CON2, 16'h0086);
      wr(4, icdt_pkg::REG_CON1, 16'h0003);
      icdt_src_i.pulses(4, 1, 4);
      repeat (8) @(posedge clock);
      rd(4, icdt_pkg::REG_CON1, 16'h0003, 16'hFFFF);
      // Counter must not move before the trigger event
      rd(4, icdt_pkg::REG_CNT, 16'h0000, 16'h0000);
      repeat (10) @(posedge clock);
      rd(4, icdt_pkg::REG_CNT, last_rd[15:0], 16'hFFFF);
      icdt_src_i.sync_pulse(6);
      repeat (4) @(posedge clock);
      rd(4, icdt_pkg::REG_CON2, 16'h00C6, 16'hFFFF);
      wr(4, icdt_pkg::REG_CON2, 16'h0086);
      rd(4, icdt_pkg::REG_CON2, 16'h0086, 16'hFFFF);
      // Software trigger: nothing until status is set by a write
      wr(5, icdt_pkg::REG_CON2, 16'h0080);
      wr(5, icdt_pkg::REG_CON1, 16'h0003);
      icdt_src_i.pulses(5, 1, 4);
      repeat (8) @(posedge clock);
      rd(5, icdt_pkg::REG_CON1, 16'h0003, 16'hFFFF);
      wr(5, icdt_pkg::REG_CON2, 16'h00C0);
      icdt_src_i.pulses(5, 1, 4);
      repeat (8) @(posedge clock);
      rd(5, icdt_pkg::REG_CON1, 16'h000B, 16'hFFFF);
      // Pin clock 1: counter steps only on that pin's rising edges
      wr(6, icdt_pkg::REG_CON1, 16'h0403);
      rd(6, icdt_pkg::REG_CNT, 16'h0000, 16'h0000);
      icdt_src_i.pin_clock(0, 3);
      repeat (8) @(posedge clock);
      rd(6, icdt_pkg::REG_CNT, last_rd[15:0] + 16'h0003, 16'hFFFF);
      icdt_src_i.pulses(6, 1, 4);
      repeat (8) @(posedge clock);
      rd(6, icdt_pkg::REG_FIFO, last_rd[15:0], 16'hFFFF);
      // Cascade 0/1, synced clear, run past one low-half wrap
      wr(1, icdt_pkg::REG_CON2, 16'h0100);
      wr(0, icdt_pkg::REG_CON2, 16'h0107);
      wr(0, icdt_pkg::REG_CON1, 16'h0003);
      icdt_src_i.enable(7, 1'b1);
      icdt_src_i.sync_pulse(7);
      repeat (70000) @(posedge clock);
      icdt_src_i.pulses(0, 1, 4);
      repeat (8) @(posedge clock);
      rd(0, icdt_pkg::REG_FIFO, 16'h1170, 16'hFFF0);
      rd(1, icdt_pkg::REG_FIFO, 16'h0001, 16'hFFFF);
      repeat (4) @(posedge clock);
      give_verdict();
   end
endmodule : tb_top
